/* File: logic/spe_link_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface spe_link_if;
  logic serial_in_pin;
  logic ss_n;
  logic serial_out_pin;
  logic [7:0] tx_byte;
  logic [7:0] rx_word;
  logic done_tgl;
  logic rst;
  modport link (input serial_in_pin, input ss_n, input tx_byte, input rst, output serial_out_pin, output rx_word,
    output done_tgl);
  modport core (output serial_in_pin, output ss_n, output tx_byte, output rst, input serial_out_pin, input rx_word,
    input done_tgl);
endinterface : spe_link_if
`default_nettype wire

/* File: logic/spe_pkg.sv */
package spe_pkg;
  // Pin slots shared by both serial modes
  localparam int PIN_COUNT = 4;
  localparam int PIN_SCK = 0;
  localparam int PIN_SDI = 1;
  localparam int PIN_SDO = 2;
  localparam int PIN_SS = 3;
  localparam int PIN_SCL = PIN_SCK;
  localparam int PIN_SDA = PIN_SDI;
  localparam int BYTE_W = 8;
  // Master serial clock: half period in ns, rounded up to system clock cycles
  localparam int MST_HALF_NS = 100;
  localparam int CLK_NS = 50;
  localparam logic [3:0] MST_HALF_CYC = 4'((MST_HALF_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] BUF_RST = 8'h00;
  localparam logic [2:0] BIT_LAST = 3'h7;
  typedef enum {
    SPE_IDLE,
    SPE_LOW,
    SPE_HIGH
  } spe_mst_t;
endpackage : spe_pkg

/* File: logic/spe_port.sv */
// Functional notes
// - In serial-peripheral mode an enabled port owns the clock, data out, data in and select pins.
// - A disabled port returns all its pins to general-purpose use.
// - In two-wire mode an enabled port owns the data and clock pins.
// - A slave byte completing while the buffer still holds an unread byte sets the overflow flag.
// - Overflow can only be raised while the port is a slave.
// - Master operation never raises overflow; a completing master byte overwrites any unread byte.
`timescale 1ns/10ps
`default_nettype none
module spe_port
  import spe_pkg::*;
(
  // System
  input wire logic CLK_I,
  input wire logic RST_I,
  // Slave link clock
  input wire logic LINK_SCK_I,
  // Control levels
  input wire logic PORT_ENABLE_BIT_I,
  input wire logic I2C_MODE_I,
  input wire logic MASTER_MODE_I,
  // Buffer access
  input wire logic BUF_WR_I,
  input wire logic [7:0] BUF_WDATA_I,
  input wire logic BUF_RD_I,
  output logic [7:0] SERIAL_RX_TX_BUFFER_O,
  output logic BUF_FULL_O,
  output logic BUSY_O,
  // Overflow flag
  input wire logic OVF_CLR_I,
  output logic OVERFLOW_O,
  // General-purpose side of the pins
  input wire logic [3:0] GPIO_OUT_I,
  input wire logic [3:0] GPIO_OE_N_I,
  output logic [3:0] GPIO_IN_O,
  // Pins
  input wire logic [3:0] PIN_I,
  output logic [3:0] PIN_O,
  output logic [3:0] PIN_OE_N_O
);
  spe_link_if lnk ();

  spe_slave_shift u_slave (
    .sck_i(LINK_SCK_I),
    .lnk(lnk)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Pin input synchronisers

  logic [3:0] pin_s1;
  logic [3:0] pin_s2;
  logic [3:0] next_pin_s1;
  logic [3:0] next_pin_s2;

  always_comb begin
    next_pin_s1 = PIN_I;
    next_pin_s2 = pin_s1;
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      pin_s1 <= 4'h0;
      pin_s2 <= 4'h0;
    end else begin
      pin_s1 <= next_pin_s1;
      pin_s2 <= next_pin_s2;
    end
  end

  assign GPIO_IN_O = pin_s2;

  ////////////////////////////////////////////////////////////////////////////
  // Slave byte arrival crossing

  logic tgl_s1;
  logic tgl_s2;
  logic tgl_s3;
  logic next_tgl_s1;
  logic next_tgl_s2;
  logic next_tgl_s3;
  logic slv_done;

  always_comb begin
    next_tgl_s1 = lnk.done_tgl;
    next_tgl_s2 = tgl_s1;
    next_tgl_s3 = tgl_s2;
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      tgl_s1 <= 1'b0;
      tgl_s2 <= 1'b0;
      tgl_s3 <= 1'b0;
    end else begin
      tgl_s1 <= next_tgl_s1;
      tgl_s2 <= next_tgl_s2;
      tgl_s3 <= next_tgl_s3;
    end
  end

  // Word is stable long before the toggle lands here
  assign slv_done = (tgl_s2 ^ tgl_s3) & PORT_ENABLE_BIT_I & ~I2C_MODE_I & ~MASTER_MODE_I;

  assign lnk.rst = RST_I;
  assign lnk.serial_in_pin = PIN_I[PIN_SDI];
  assign lnk.ss_n = PIN_I[PIN_SS] | ~PORT_ENABLE_BIT_I | MASTER_MODE_I | I2C_MODE_I;

  ////////////////////////////////////////////////////////////////////////////
  // Master engine, buffer and overflow

  spe_mst_t st;
  spe_mst_t next_st;
  logic [3:0] tmr;
  logic [3:0] next_tmr;
  logic [2:0] bitn;
  logic [2:0] next_bitn;
  logic [7:0] shf;
  logic [7:0] next_shf;
  logic [7:0] tx_byte;
  logic [7:0] next_tx_byte;
  logic [7:0] buf_data;
  logic [7:0] next_buf_data;
  logic buf_full;
  logic next_buf_full;
  logic ovf;
  logic next_ovf;
  logic mst_done;
  logic mst_en;

  assign mst_en = PORT_ENABLE_BIT_I & MASTER_MODE_I & ~I2C_MODE_I;

  always_comb begin
    next_st = st;
    next_tmr = tmr;
    next_bitn = bitn;
    next_shf = shf;
    next_tx_byte = tx_byte;
    mst_done = 1'b0;
    if (BUF_WR_I) begin
      next_tx_byte = BUF_WDATA_I;
    end
    case (st)
      SPE_IDLE: begin
        // Each master transfer starts only from a buffer write
        if (BUF_WR_I && mst_en) begin
          next_st = SPE_LOW;
          next_tmr = MST_HALF_CYC;
          next_bitn = 3'h0;
          next_shf = BUF_WDATA_I;
        end
      end
      SPE_LOW: begin
        next_tmr = tmr - 4'h1;
        if (tmr == 4'h1) begin
          next_st = SPE_HIGH;
          next_tmr = MST_HALF_CYC;
        end
      end
      SPE_HIGH: begin
        next_tmr = tmr - 4'h1;
        if (tmr == 4'h1) begin
          next_tmr = MST_HALF_CYC;
          // Sync lag equals a half period: this is the pin as at the rising edge
          next_shf = {shf[6:0], pin_s2[PIN_SDI]};
          next_bitn = bitn + 3'h1;
          next_st = SPE_LOW;
          if (bitn == BIT_LAST) begin
            next_st = SPE_IDLE;
            mst_done = 1'b1;
          end
        end
      end
      default: begin
        next_st = SPE_IDLE;
      end
    endcase
    // Disabling aborts any transfer in flight
    if (!mst_en) begin
      next_st = SPE_IDLE;
    end
  end

  always_comb begin
    next_buf_data = buf_data;
    next_buf_full = buf_full;
    next_ovf = ovf;
    // Clear first so a same-cycle event still wins
    if (BUF_RD_I) begin
      next_buf_full = 1'b0;
    end
    if (OVF_CLR_I) begin
      next_ovf = 1'b0;
    end
    if (mst_done) begin
      next_buf_data = next_shf;
      next_buf_full = 1'b1;
    end else if (slv_done) begin
      if (buf_full && !BUF_RD_I) begin
        next_ovf = 1'b1;
        next_buf_data = buf_data;
      end else begin
        next_buf_data = lnk.rx_word;
        next_buf_full = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      st <= SPE_IDLE;
      tmr <= 4'h0;
      bitn <= 3'h0;
      shf <= BUF_RST;
      tx_byte <= BUF_RST;
      buf_data <= BUF_RST;
      buf_full <= 1'b0;
      ovf <= 1'b0;
    end else begin
      st <= next_st;
      tmr <= next_tmr;
      bitn <= next_bitn;
      shf <= next_shf;
      tx_byte <= next_tx_byte;
      buf_data <= next_buf_data;
      buf_full <= next_buf_full;
      ovf <= next_ovf;
    end
  end

  // Slave sends the last written byte; software must not write mid-frame
  assign lnk.tx_byte = tx_byte;

  assign SERIAL_RX_TX_BUFFER_O = buf_data;
  assign BUF_FULL_O = buf_full;
  assign OVERFLOW_O = ovf;
  assign BUSY_O = (st != SPE_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // Pin ownership

  logic [3:0] port_val;
  logic [3:0] port_own;

  always_comb begin
    port_val = 4'h0;
    port_own = 4'h0;
    if (PORT_ENABLE_BIT_I && !I2C_MODE_I) begin
      port_own = 4'hf;
      port_val[PIN_SCK] = (st == SPE_HIGH);
      port_val[PIN_SDO] = mst_en ? shf[7] : lnk.serial_out_pin;
    end else if (PORT_ENABLE_BIT_I) begin
      // Open-drain pair: pulls low, user direction releases
      port_own[PIN_SCL] = 1'b1;
      port_own[PIN_SDA] = 1'b1;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < PIN_COUNT; gi++) begin : g_pin
      assign PIN_O[gi] = port_own[gi] ? port_val[gi] : GPIO_OUT_I[gi];
      // Direction is never forced by the port
      assign PIN_OE_N_O[gi] = GPIO_OE_N_I[gi];
    end
  endgenerate
endmodule : spe_port
`default_nettype wire

/* File: logic/spe_slave_shift.sv */
`timescale 1ns/10ps
`default_nettype none
module spe_slave_shift
  import spe_pkg::*;
(
  // Link clock from the master
  input wire logic sck_i,
  spe_link_if.link lnk
);
  logic [2:0] cnt;
  logic [6:0] shf;
  logic [7:0] rx_word;
  logic done_tgl;
  logic [2:0] next_cnt;
  logic [6:0] next_shf;
  logic [7:0] next_rx_word;
  logic next_done_tgl;

  always_comb begin
    next_cnt = cnt + 3'h1;
    next_shf = {shf[5:0], lnk.serial_in_pin};
    next_rx_word = rx_word;
    next_done_tgl = done_tgl;
    if (cnt == BIT_LAST) begin
      next_rx_word = {shf, lnk.serial_in_pin};
      next_done_tgl = ~done_tgl;
    end
  end

  // Deselect ends the frame; the clock may stop right after it
  always_ff @(posedge sck_i or posedge lnk.ss_n) begin
    if (lnk.ss_n) begin
      cnt <= 3'h0;
      shf <= 7'h00;
    end else begin
      cnt <= next_cnt;
      shf <= next_shf;
    end
  end

  // Word and toggle survive deselect so the core can still fetch them
  // Toggle needs a known start or every later byte stays unknown
  always_ff @(posedge sck_i or posedge lnk.rst) begin
    if (lnk.rst) begin
      rx_word <= 8'h00;
      done_tgl <= 1'b0;
    end else if (!lnk.ss_n) begin
      rx_word <= next_rx_word;
      done_tgl <= next_done_tgl;
    end
  end

  // Output bit moves after each sampling edge
  assign lnk.serial_out_pin = lnk.tx_byte[3'h7 - cnt];
  assign lnk.rx_word = rx_word;
  assign lnk.done_tgl = done_tgl;
endmodule : spe_slave_shift
`default_nettype wire

/* File: tb/spe_peer.sv */
`timescale 1ns/10ps
`default_nettype none
module spe_peer (
  // Link side
  output var logic sck_o,
  output var logic ss_n_o,
  output var logic sdi_o,
  input wire logic sdo_i
);
  logic [7:0] got;
  initial begin
    sck_o = 1'b0;
    ss_n_o = 1'b1;
    sdi_o = 1'b0;
  end
  // Clock stands still outside frames, 48 ns inside
  task automatic frame(input logic [7:0] d);
    #7 ss_n_o = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      sdi_o = d[i];
      #24 got[i] = sdo_i;
      sck_o = 1'b1;
      #24 sck_o = 1'b0;
    end
    #24 ss_n_o = 1'b1;
    // Released line must not look held
    sdi_o = ~sdi_o;
  endtask : frame
endmodule : spe_peer
`default_nettype wire

/* File: tb/spe_port_properties.sv */
`timescale 1ns/10ps
`default_nettype none
module spe_port_properties (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic PORT_ENABLE_BIT_I,
  input wire logic I2C_MODE_I,
  input wire logic MASTER_MODE_I,
  input wire logic [7:0] BUF_WDATA_I,
  input wire logic OVF_CLR_I,
  input wire logic [7:0] SERIAL_RX_TX_BUFFER_O,
  input wire logic BUF_FULL_O,
  input wire logic BUSY_O,
  input wire logic OVERFLOW_O,
  input wire logic [3:0] GPIO_OUT_I,
  input wire logic [3:0] PIN_O
);
  logic [7:0] wd_q;
  always_ff @(posedge CLK_I) wd_q <= BUF_WDATA_I;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  AST_OFF_GPIO: assert property (!PORT_ENABLE_BIT_I |-> PIN_O == GPIO_OUT_I)
    else $error("pins not returned to gpio");
  AST_TWO_WIRE: assert property (PORT_ENABLE_BIT_I && I2C_MODE_I |-> PIN_O[1:0] == 2'h0)
    else $error("two-wire pins not claimed");
  AST_MST_FIRST: assert property ($rose(BUSY_O) |-> !PIN_O[0] && PIN_O[2] == wd_q[7])
    else $error("master pins wrong at start");
  AST_MST_LEN: assert property ($rose(BUSY_O) |-> ##31 BUSY_O ##1 !BUSY_O)
    else $error("master transfer length");
  AST_MST_END: assert property ($fell(BUSY_O) |-> BUF_FULL_O && !$rose(OVERFLOW_O))
    else $error("master end wrong");
  AST_OVF_SLAVE: assert property ($rose(OVERFLOW_O) |-> $past(PORT_ENABLE_BIT_I) &&
    !$past(MASTER_MODE_I) && !$past(I2C_MODE_I))
    else $error("overflow outside slave");
  AST_OVF_FULL: assert property ($rose(OVERFLOW_O) |-> $past(BUF_FULL_O))
    else $error("overflow without unread byte");
  AST_OVF_KEEP: assert property ($rose(OVERFLOW_O) |-> $stable(SERIAL_RX_TX_BUFFER_O))
    else $error("overflow replaced byte");
  AST_OVF_STICKY: assert property (OVERFLOW_O && !OVF_CLR_I |=> OVERFLOW_O)
    else $error("overflow cleared by hardware");
  cover property ($rose(OVERFLOW_O));
  cover property ($fell(BUSY_O));
  cover property (PORT_ENABLE_BIT_I && I2C_MODE_I);
endmodule : spe_port_properties
bind spe_port spe_port_properties chk (.CLK_I(CLK_I), .RST_I(RST_I),
  .PORT_ENABLE_BIT_I(PORT_ENABLE_BIT_I), .I2C_MODE_I(I2C_MODE_I),
  .MASTER_MODE_I(MASTER_MODE_I), .BUF_WDATA_I(BUF_WDATA_I), .OVF_CLR_I(OVF_CLR_I),
  .SERIAL_RX_TX_BUFFER_O(SERIAL_RX_TX_BUFFER_O), .BUF_FULL_O(BUF_FULL_O),
  .BUSY_O(BUSY_O), .OVERFLOW_O(OVERFLOW_O), .GPIO_OUT_I(GPIO_OUT_I), .PIN_O(PIN_O));
`default_nettype wire

/* File: tb/spe_port_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module spe_port_tb;
  logic clk = 1'b0, rst = 1'b1, en = 1'b0, i2c = 1'b0, mst = 1'b0, full, busy, ovf;
  logic [2:0] ctl = 3'h0;
  logic [7:0] wd = 8'h00, b, c, q;
  logic [3:0] gp = 4'h0, oe_n = 4'hf, po, po_oe, gi;
  wire logic sck, ss_n, serial_in_pin;
  wire logic [3:0] pin_i;
  int err_total = 0, checks = 0;
  // Master loops data out back to data in
  assign pin_i = mst ? {1'b1, po[2], po[2], po[0]} : {ss_n, po[2], serial_in_pin, sck};
  spe_peer p (.sck_o(sck), .ss_n_o(ss_n), .sdi_o(serial_in_pin), .sdo_i(po[2]));
  spe_port uut (.CLK_I(clk), .RST_I(rst), .LINK_SCK_I(pin_i[0]), .PORT_ENABLE_BIT_I(en),
    .I2C_MODE_I(i2c), .MASTER_MODE_I(mst), .BUF_WR_I(ctl[0]), .BUF_WDATA_I(wd),
    .BUF_RD_I(ctl[1]), .SERIAL_RX_TX_BUFFER_O(q), .BUF_FULL_O(full), .BUSY_O(busy),
    .OVF_CLR_I(ctl[2]), .OVERFLOW_O(ovf), .GPIO_OUT_I(gp), .GPIO_OE_N_I(oe_n),
    .GPIO_IN_O(gi), .PIN_I(pin_i), .PIN_O(po), .PIN_OE_N_O(po_oe));
  initial forever #25 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] keep(input logic f, input logic [7:0] o, input logic [7:0] n);
    return f ? o : n;
  endfunction : keep
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %0t got %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic pls(input logic [2:0] m, input logic [7:0] d);
    @(posedge clk) ctl <= m;
    wd <= d;
    @(posedge clk) ctl <= 3'h0;
  endtask : pls
  task automatic slv(input logic [7:0] d);
    p.frame(d);
    repeat (6) @(posedge clk);
    @(negedge clk);
  endtask : slv
  task automatic conclude;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #500000 err_total++;
    conclude;
  end
  initial begin
    void'($urandom(32'hed7b));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk) gp <= 4'($urandom);
    @(negedge clk) chk({4'h0, po}, {4'h0, gp});
    @(posedge clk) {en, i2c} <= 2'h3;
    @(negedge clk) chk({6'h0, po[1:0]}, 8'h00);
    @(posedge clk) i2c <= 1'b0;
    oe_n <= 4'h4;
    // Warm-up byte, then flags cleared
    slv(8'h00);
    chk({4'h0, po_oe}, 8'h04);
    pls(3'h6, 8'h00);
    repeat (3) begin
      b = 8'($urandom);
      c = 8'($urandom);
      pls(3'h1, c);
      slv(b);
      chk(q, b);
      chk(p.got, c);
      chk({7'h0, ovf}, 8'h00);
      slv(c);
      chk({7'h0, ovf}, 8'h01);
      chk(q, keep(1'b1, b, c));
      pls(3'h6, 8'h00);
      @(negedge clk) chk({6'h0, ovf, full}, 8'h00);
    end
    @(posedge clk) en <= 1'b0;
    slv(8'($urandom));
    chk({7'h0, full}, 8'h00);
    @(posedge clk) {en, mst} <= 2'h3;
    repeat (3) begin
      b = 8'($urandom);
      pls(3'h1, b);
      repeat (34) @(posedge clk);
      @(negedge clk) chk(q, b);
      chk({6'h0, ovf, full}, 8'h01);
      chk({4'h0, gi}, {4'h0, pin_i});
    end
    conclude;
  end
endmodule : spe_port_tb
`default_nettype wire
